// >>> inc/jlp_pkg.sv
// Shared constants and carriers for the link parameter register bank.
// Assumes every user writes package::name; nothing is imported.
package jlp_pkg;

   // Serial port framing: 16-bit instruction then one data byte.
   localparam int ADDR_W      = 15;
   localparam int DATA_W      = 8;
   localparam int INSTR_BITS  = 16;
   localparam int CNT_W       = 4;
   localparam int NUM_REGS    = 11;

   // Register indices into the bank.
   localparam int IDX_LANE    = 0;
   localparam int IDX_OPF     = 1;
   localparam int IDX_KFR     = 2;
   localparam int IDX_CONV    = 3;
   localparam int IDX_RES     = 4;
   localparam int IDX_SUBC    = 5;
   localparam int IDX_VERS    = 6;
   localparam int IDX_DENS    = 7;
   localparam int IDX_DESKEW  = 8;
   localparam int IDX_OPF_PL  = 9;
   localparam int IDX_LANE_EN = 10;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] ADDR_LANE_COUNT_SCRAMBLE_CFG     = 15'h0453;
   localparam logic [ADDR_W-1:0] ADDR_OCTETS_PER_FRAME_MINUS1     = 15'h0454;
   localparam logic [ADDR_W-1:0] ADDR_FRAMES_PER_MULTIFRAME_CFG   = 15'h0455;
   localparam logic [ADDR_W-1:0] ADDR_CONVERTER_COUNT_CFG         = 15'h0456;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL_BITS_RESOLUTION_CFG = 15'h0457;
   localparam logic [ADDR_W-1:0] ADDR_SUBCLASS_SAMPLE_WIDTH_CFG   = 15'h0458;
   localparam logic [ADDR_W-1:0] ADDR_VERSION_SAMPLES_CFG         = 15'h0459;
   localparam logic [ADDR_W-1:0] ADDR_DENSITY_CONTROL_WORDS_CFG   = 15'h045A;
   localparam logic [ADDR_W-1:0] ADDR_LANE_DESKEW_MASK            = 15'h046C;
   localparam logic [ADDR_W-1:0] ADDR_OCTETS_PER_FRAME_PLAIN      = 15'h0476;
   localparam logic [ADDR_W-1:0] ADDR_LANE_ENABLE_MASK            = 15'h047D;

   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
      ADDR_LANE_COUNT_SCRAMBLE_CFG, ADDR_OCTETS_PER_FRAME_MINUS1,
      ADDR_FRAMES_PER_MULTIFRAME_CFG, ADDR_CONVERTER_COUNT_CFG,
      ADDR_CONTROL_BITS_RESOLUTION_CFG, ADDR_SUBCLASS_SAMPLE_WIDTH_CFG,
      ADDR_VERSION_SAMPLES_CFG, ADDR_DENSITY_CONTROL_WORDS_CFG,
      ADDR_LANE_DESKEW_MASK, ADDR_OCTETS_PER_FRAME_PLAIN, ADDR_LANE_ENABLE_MASK};

   // Reset contents: one lane, two octets, one converter, a consistent set.
   localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
      8'h00, 8'h01, 8'h1F, 8'h00, 8'h0F, 8'h0F, 8'h20, 8'h00, 8'h01, 8'h02, 8'h01};

   // Field positions.
   localparam int SCR_BIT   = 7;
   localparam int CNT_MSB   = 4;
   localparam int CNT_LSB   = 0;
   localparam int TOP_MSB   = 7;
   localparam int SUB_LSB   = 5;
   localparam int CS_LSB    = 6;
   localparam int HD_BIT    = 7;

   // Values that software must program, and legal codes.
   localparam logic [4:0] FIELD_16BIT = 5'h0F;
   localparam logic [4:0] CW_NONE     = 5'h00;
   localparam logic [1:0] CS_NONE     = 2'h0;
   localparam logic [2:0] SUBCLASS_0  = 3'h0;
   localparam logic [2:0] SUBCLASS_1  = 3'h1;
   localparam logic [2:0] VERSION_B   = 3'h1;
   localparam logic [4:0] K_32_CODE   = 5'h1F;
   localparam logic [4:0] L_TWO_CODE  = 5'h01;
   localparam logic [7:0] M_ONE_CODE  = 8'h00;

   // Serial phases.
   typedef enum logic [1:0] {
      SP_INSTR = 2'b00,
      SP_DATA  = 2'b01,
      SP_DONE  = 2'b10
   } jlp_phase_e;

   // Register access request from the serial port.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } jlp_req_s;

   // Decoded link parameters, counts as true counts, flags and masks as stored.
   typedef struct packed {
      logic       descramble_en;
      logic [5:0] lanes;
      logic [8:0] octets;
      logic [5:0] frames;
      logic [8:0] converters;
      logic       subclass1;
      logic [5:0] samples;
      logic       high_density;
      logic [7:0] deskew_mask;
      logic [7:0] lane_enable;
   } jlp_link_cfg_s;

   // Consistency flags, high when software broke a programming convention.
   typedef struct packed {
      logic plain_f_mismatch;
      logic ctrl_bits_set;
      logic resolution_bad;
      logic np_bad;
      logic version_bad;
      logic ctrl_words_set;
      logic subclass_bad;
      logic k_illegal;
   } jlp_check_s;

endpackage

// >>> rtl/jlp_link_param_regs.sv
// Link parameter register bank for the serial-lane receiver, with decoded outputs.
// Assumes the deframer consumes link_cfg_out and that software writes the bank over the serial port.
//
// Operation
// RULE_01 - Lane-configuration bit 7 high turns descrambling on, low turns it off.
// RULE_02 - Lane-configuration bits 4..0 hold lane count minus one.
// RULE_03 - Coded frame-size register holds octets per frame minus one.
// RULE_04 - Software also writes octets per frame uncoded into the plain frame-size register.
// RULE_05 - Multiframe bits 4..0 hold frames minus one; one converter two lanes needs 32.
// RULE_06 - Converter-count register holds converters per link minus one.
// RULE_07 - Software writes zero control bits per sample in resolution bits 7..6.
// RULE_08 - Software programs resolution bits 4..0 to sixteen-bit resolution.
// RULE_09 - Subclass bits 7..5 select subclass 0 or subclass 1 operation.
// RULE_10 - Software programs subclass bits 4..0 for sixteen total bits per sample.
// RULE_11 - Software sets version bits 7..5 to declare the link version.
// RULE_12 - Version bits 4..0 hold samples per converter per frame minus one.
// RULE_13 - Density bit 7 enables high-density mapping where samples may span lanes.
// RULE_14 - Software writes zero control words per frame into density bits 4..0.
// RULE_15 - Each set bit of the deskew mask includes that lane in deskew.
// RULE_16 - Each set bit of the lane-enable mask activates that lane.
`timescale 1ns/10ps
module jlp_link_param_regs
(
   // Clock and reset.
   input  wire logic            ref_clk_in,
   input  wire logic            rst_n_in,
   // Serial register port pins.
   input  wire logic            sclk_in,
   input  wire logic            csb_n_in,
   input  wire logic            sdi_in,
   output logic                 sdo_out,
   output logic                 sdo_oe_out,
   // Decoded link parameters and consistency flags.
   output jlp_pkg::jlp_link_cfg_s link_cfg_out,
   output jlp_pkg::jlp_check_s    cfg_check_out
);
   jlp_pkg::jlp_req_s           req;
   logic [jlp_pkg::DATA_W-1:0]  regs      [jlp_pkg::NUM_REGS];
   logic [jlp_pkg::DATA_W-1:0]  next_regs [jlp_pkg::NUM_REGS];
   logic [jlp_pkg::NUM_REGS-1:0] hit;
   logic [jlp_pkg::DATA_W-1:0]  rd_data, next_rd_data;
   logic                        rd_valid;
   jlp_pkg::jlp_link_cfg_s      cfg, next_cfg;
   jlp_pkg::jlp_check_s         chk, next_chk;

   // Serial framing lives in its own module.
   jlp_spi_port u_spi
   (
      .ref_clk_in  (ref_clk_in),
      .rst_n_in    (rst_n_in),
      .sclk_in     (sclk_in),
      .csb_n_in    (csb_n_in),
      .sdi_in      (sdi_in),
      .sdo_out     (sdo_out),
      .sdo_oe_out  (sdo_oe_out),
      .req_out     (req),
      .rd_valid_in (rd_valid),
      .rd_data_in  (rd_data)
   );

   // Per-entry address match and write; unmapped addresses hit nothing.
   genvar gi;
   generate
      for (gi = 0; gi < jlp_pkg::NUM_REGS; gi++)
      begin : g_reg
         assign hit[gi] = (req.addr == jlp_pkg::REG_ADDR[gi]);
         always_comb
         begin
            next_regs[gi] = regs[gi];
            if (req.wr && hit[gi])
               next_regs[gi] = req.wdata;
         end
         always_ff @(posedge ref_clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
               regs[gi] <= jlp_pkg::REG_RESET[gi];
            else
               regs[gi] <= next_regs[gi];
         end
      end
   endgenerate

   // Readback; an unmapped address reads as zero rather than stale data.
   always_comb
   begin
      next_rd_data = rd_data;
      if (req.rd)
      begin
         next_rd_data = '0;
         for (int i = 0; i < jlp_pkg::NUM_REGS; i++)
            if (hit[i])
               next_rd_data = regs[i];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_data  <= next_rd_data;
         rd_valid <= req.rd;
      end
   end

   // Decode the link fields for the deframer, counts as true counts, flags and masks as stored.
   always_comb
   begin
      next_cfg.descramble_en = regs[jlp_pkg::IDX_LANE][jlp_pkg::SCR_BIT];                          // see RULE_01
      next_cfg.lanes         = 6'(regs[jlp_pkg::IDX_LANE][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]) + 6'h01; // see RULE_02
      next_cfg.octets        = 9'(regs[jlp_pkg::IDX_OPF]) + 9'h001;                                 // see RULE_03
      next_cfg.frames        = 6'(regs[jlp_pkg::IDX_KFR][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]) + 6'h01;  // see RULE_05
      next_cfg.converters    = 9'(regs[jlp_pkg::IDX_CONV]) + 9'h001;                                // see RULE_06
      next_cfg.subclass1     = (regs[jlp_pkg::IDX_SUBC][jlp_pkg::TOP_MSB:jlp_pkg::SUB_LSB]
                                == jlp_pkg::SUBCLASS_1);                                           // see RULE_09
      next_cfg.samples       = 6'(regs[jlp_pkg::IDX_VERS][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]) + 6'h01; // see RULE_12
      next_cfg.high_density  = regs[jlp_pkg::IDX_DENS][jlp_pkg::HD_BIT];                           // see RULE_13
      next_cfg.deskew_mask   = regs[jlp_pkg::IDX_DESKEW];                                           // see RULE_15
      next_cfg.lane_enable   = regs[jlp_pkg::IDX_LANE_EN];                                          // see RULE_16
   end

   // Flag software settings that break the fixed conventions; the deframer may hold off on them.
   always_comb
   begin
      next_chk.plain_f_mismatch = (9'(regs[jlp_pkg::IDX_OPF_PL])
                                   != 9'(regs[jlp_pkg::IDX_OPF]) + 9'h001);                        // see RULE_04
      next_chk.ctrl_bits_set    = (regs[jlp_pkg::IDX_RES][jlp_pkg::TOP_MSB:jlp_pkg::CS_LSB]
                                   != jlp_pkg::CS_NONE);                                           // see RULE_07
      next_chk.resolution_bad   = (regs[jlp_pkg::IDX_RES][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]
                                   != jlp_pkg::FIELD_16BIT);                                       // see RULE_08
      next_chk.np_bad           = (regs[jlp_pkg::IDX_SUBC][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]
                                   != jlp_pkg::FIELD_16BIT);                                       // see RULE_10
      next_chk.version_bad      = (regs[jlp_pkg::IDX_VERS][jlp_pkg::TOP_MSB:jlp_pkg::SUB_LSB]
                                   != jlp_pkg::VERSION_B);                                         // see RULE_11
      next_chk.ctrl_words_set   = (regs[jlp_pkg::IDX_DENS][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]
                                   != jlp_pkg::CW_NONE);                                           // see RULE_14
      next_chk.subclass_bad     = (regs[jlp_pkg::IDX_SUBC][jlp_pkg::TOP_MSB:jlp_pkg::SUB_LSB]
                                   != jlp_pkg::SUBCLASS_0)
                                  && !next_cfg.subclass1;                                          // see RULE_09
      // One converter on two lanes only works with 32-frame multiframes.
      next_chk.k_illegal        = (regs[jlp_pkg::IDX_CONV] == jlp_pkg::M_ONE_CODE)
                                  && (regs[jlp_pkg::IDX_LANE][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]
                                      == jlp_pkg::L_TWO_CODE)
                                  && (regs[jlp_pkg::IDX_KFR][jlp_pkg::CNT_MSB:jlp_pkg::CNT_LSB]
                                      != jlp_pkg::K_32_CODE);                                      // see RULE_05
   end

   // Output registers keep the deframer's view glitch-free.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cfg <= '0;
         chk <= '0;
      end
      else
      begin
         cfg <= next_cfg;
         chk <= next_chk;
      end
   end

   assign link_cfg_out  = cfg;
   assign cfg_check_out = chk;

   // Checks: a write lands in the bank one edge later and on the outputs two edges later.
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_write(logic [jlp_pkg::ADDR_W-1:0] a);
      req.wr && req.addr == a;
   endsequence

   AST_DESCRAMBLE: assert property (s_write(jlp_pkg::ADDR_LANE_COUNT_SCRAMBLE_CFG) |-> // see RULE_01
      ##2 link_cfg_out.descramble_en == $past(req.wdata[7], 2))
      else $error("Descramble enable does not follow lane configuration bit 7.");

   AST_LANES: assert property (s_write(jlp_pkg::ADDR_LANE_COUNT_SCRAMBLE_CFG) |-> // see RULE_02
      ##2 link_cfg_out.lanes == 6'($past(req.wdata[4:0], 2)) + 6'h01)
      else $error("Lane count is not field plus one.");

   AST_OCTETS: assert property (s_write(jlp_pkg::ADDR_OCTETS_PER_FRAME_MINUS1) |-> // see RULE_03
      ##2 link_cfg_out.octets == 9'($past(req.wdata, 2)) + 9'h001)
      else $error("Octets per frame is not register plus one.");

   AST_PLAIN_F: assert property (s_write(jlp_pkg::ADDR_OCTETS_PER_FRAME_PLAIN) ##1 // see RULE_04
      (regs[jlp_pkg::IDX_OPF] == 8'h03) |=> cfg_check_out.plain_f_mismatch == ($past(req.wdata, 2) != 8'h04))
      else $error("Plain frame size mismatch flag is wrong.");

   AST_FRAMES: assert property (s_write(jlp_pkg::ADDR_FRAMES_PER_MULTIFRAME_CFG) |-> // see RULE_05
      ##2 link_cfg_out.frames == 6'($past(req.wdata[4:0], 2)) + 6'h01)
      else $error("Frames per multiframe is not field plus one.");

   AST_K_ILLEGAL: assert property ( // see RULE_05
      (regs[jlp_pkg::IDX_CONV] == 8'h00 && regs[jlp_pkg::IDX_LANE][4:0] == 5'h01
       && regs[jlp_pkg::IDX_KFR][4:0] == 5'h0F) |=> cfg_check_out.k_illegal)
      else $error("Sixteen-frame multiframe on one converter two lanes not flagged.");

   AST_CONVERTERS: assert property (s_write(jlp_pkg::ADDR_CONVERTER_COUNT_CFG) |-> // see RULE_06
      ##2 link_cfg_out.converters == 9'($past(req.wdata, 2)) + 9'h001)
      else $error("Converter count is not register plus one.");

   AST_SUBCLASS: assert property (s_write(jlp_pkg::ADDR_SUBCLASS_SAMPLE_WIDTH_CFG) |-> // see RULE_09
      ##2 link_cfg_out.subclass1 == ($past(req.wdata[7:5], 2) == 3'h1))
      else $error("Subclass selection does not follow bits 7 to 5.");

   AST_SAMPLES: assert property (s_write(jlp_pkg::ADDR_VERSION_SAMPLES_CFG) |-> // see RULE_12
      ##2 link_cfg_out.samples == 6'($past(req.wdata[4:0], 2)) + 6'h01)
      else $error("Samples per frame is not field plus one.");

   AST_DENSITY: assert property (s_write(jlp_pkg::ADDR_DENSITY_CONTROL_WORDS_CFG) |-> // see RULE_13
      ##2 link_cfg_out.high_density == $past(req.wdata[7], 2))
      else $error("High density does not follow density bit 7.");

   AST_DESKEW: assert property (s_write(jlp_pkg::ADDR_LANE_DESKEW_MASK) |-> // see RULE_15
      ##2 link_cfg_out.deskew_mask == $past(req.wdata, 2))
      else $error("Deskew mask output does not match the write.");

   AST_LANE_EN: assert property (s_write(jlp_pkg::ADDR_LANE_ENABLE_MASK) |-> // see RULE_16
      ##2 link_cfg_out.lane_enable == $past(req.wdata, 2))
      else $error("Lane enable output does not match the write.");

   AST_READBACK: assert property (req.rd && req.addr == jlp_pkg::ADDR_LANE_ENABLE_MASK |=> // see RULE_16
      rd_valid && rd_data == regs[jlp_pkg::IDX_LANE_EN])
      else $error("Readback of lane enable mask is wrong.");

endmodule

// >>> rtl/jlp_spi_port.sv
// Serial register port: synchronises the pins and frames instruction and data.
// Assumes the serial clock runs at most one eighth of ref_clk_in, mode 0, MSB first.
`timescale 1ns/10ps
module jlp_spi_port
(
   // Clock and reset.
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_n_in,
   // Serial pins.
   input  wire logic                        sclk_in,
   input  wire logic                        csb_n_in,
   input  wire logic                        sdi_in,
   output logic                             sdo_out,
   output logic                             sdo_oe_out,
   // Register side.
   output jlp_pkg::jlp_req_s                req_out,
   input  wire logic                        rd_valid_in,
   input  wire logic [jlp_pkg::DATA_W-1:0]  rd_data_in
);
   logic [2:0]                  sclk_q;
   logic [1:0]                  csb_q;
   logic [1:0]                  sdi_q;
   jlp_pkg::jlp_phase_e         phase, next_phase;
   logic [jlp_pkg::CNT_W-1:0]   cnt, next_cnt;
   logic [jlp_pkg::INSTR_BITS-1:0] shreg, next_shreg;
   logic                        is_read, next_is_read;
   logic [jlp_pkg::DATA_W-1:0]  out_sh, next_out_sh;
   logic                        sdo, next_sdo;
   jlp_pkg::jlp_req_s           req, next_req;
   logic                        rise, fall, active;

   // Pin synchronisers; only the second stage onward is looked at.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sclk_q <= 3'h0;
         csb_q  <= 2'h3;
         sdi_q  <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk_in};
         csb_q  <= {csb_q[0], csb_n_in};
         sdi_q  <= {sdi_q[0], sdi_in};
      end
   end

   assign rise   = sclk_q[1] & ~sclk_q[2];
   assign fall   = ~sclk_q[1] & sclk_q[2];
   assign active = ~csb_q[1];

   // Framing: bits are taken on rising edges, read data leaves on falling ones.
   always_comb
   begin
      next_phase   = phase;
      next_cnt     = cnt;
      next_shreg   = shreg;
      next_is_read = is_read;
      next_out_sh  = out_sh;
      next_sdo     = sdo;
      next_req     = req;
      next_req.wr  = 1'b0;
      next_req.rd  = 1'b0;
      if (!active)
      begin
         next_phase   = jlp_pkg::SP_INSTR;
         next_cnt     = '0;
         next_is_read = 1'b0;
      end
      else if (rise)
      begin
         next_shreg = {shreg[jlp_pkg::INSTR_BITS-2:0], sdi_q[1]};
         next_cnt   = cnt + 1'b1;
         case (phase)
            jlp_pkg::SP_INSTR:
               if (cnt == jlp_pkg::CNT_W'(jlp_pkg::INSTR_BITS - 1))
               begin
                  next_phase    = jlp_pkg::SP_DATA;
                  next_cnt      = '0;
                  next_is_read  = shreg[jlp_pkg::INSTR_BITS-2];
                  next_req.addr = {shreg[jlp_pkg::ADDR_W-2:0], sdi_q[1]};
                  next_req.rd   = shreg[jlp_pkg::INSTR_BITS-2];
               end
            jlp_pkg::SP_DATA:
               if (cnt == jlp_pkg::CNT_W'(jlp_pkg::DATA_W - 1))
               begin
                  next_phase     = jlp_pkg::SP_DONE;
                  next_req.wr    = ~is_read;
                  next_req.wdata = {shreg[jlp_pkg::DATA_W-2:0], sdi_q[1]};
               end
            jlp_pkg::SP_DONE:
               next_phase = jlp_pkg::SP_DONE;
            default:
               next_phase = jlp_pkg::SP_INSTR;
         endcase
      end
      else if (fall && is_read && phase == jlp_pkg::SP_DATA)
      begin
         next_sdo    = out_sh[jlp_pkg::DATA_W-1];
         next_out_sh = {out_sh[jlp_pkg::DATA_W-2:0], 1'b0};
      end
      // The register answer lands long before the next falling edge.
      if (rd_valid_in)
         next_out_sh = rd_data_in;
   end

   // State registers.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         phase   <= jlp_pkg::SP_INSTR;
         cnt     <= '0;
         shreg   <= '0;
         is_read <= 1'b0;
         out_sh  <= '0;
         sdo     <= 1'b0;
         req     <= '0;
      end
      else
      begin
         phase   <= next_phase;
         cnt     <= next_cnt;
         shreg   <= next_shreg;
         is_read <= next_is_read;
         out_sh  <= next_out_sh;
         sdo     <= next_sdo;
         req     <= next_req;
      end
   end

   assign req_out    = req;
   assign sdo_out    = sdo;
   assign sdo_oe_out = active & is_read & (phase != jlp_pkg::SP_INSTR);

endmodule

// >>> sim/jlp_link_param_regs_tb_top.sv
// Self-checking bench for the link parameter bank, driven through the serial host model.
// Assumes the host model spaces frames as the serial port requires.
`timescale 1ns/10ps
module jlp_link_param_regs_tb_top;
`define CHK(s, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s: expected %h seen %h", s, e, g); end end
   typedef struct packed
   {
      logic [7:0] rd;
      jlp_pkg::jlp_link_cfg_s cfg;
      jlp_pkg::jlp_check_s chk;
   } jlp_note_s;
   // Mode settings that software programs: 7, 10, then 9; CS, N, NP, version and CF as required.
   localparam logic [7:0] MODES [3][11] = '{
      '{8'h80, 8'h03, 8'h0F, 8'h01, 8'h0F, 8'h2F, 8'h20, 8'h00, 8'h01, 8'h04, 8'h01},
      '{8'h00, 8'h01, 8'h0F, 8'h00, 8'h0F, 8'h0F, 8'h20, 8'h00, 8'h01, 8'h02, 8'h01},
      '{8'h81, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h2F, 8'h20, 8'h80, 8'h03, 8'h01, 8'h03}};
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sclk, csb_n, sdi, sdo, sdo_oe;
   jlp_pkg::jlp_link_cfg_s link_cfg_out;
   jlp_pkg::jlp_check_s cfg_check_out;
   logic [7:0] m [11];
   logic [7:0] rdat;
   logic [7:0] d;
   jlp_note_s notes [$];
   jlp_note_s cur;
   event done_ev;
   int errors = 0;
   int n_tests = 0;
   int seed = 32'h0cc3;
   int k;

   // Free running reference clock.
   always #4 ref_clk_in = ~ref_clk_in;

   jlp_link_param_regs i_jlp_link_param_regs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .sclk_in(sclk), .csb_n_in(csb_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
      .link_cfg_out(link_cfg_out), .cfg_check_out(cfg_check_out));
   jlp_spi_host i_jlp_spi_host (.ref_clk_in(ref_clk_in), .sclk_out(sclk), .csb_n_out(csb_n),
      .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));

   // Expected decode and flags from the bench's own copy of the bank.
   function automatic jlp_note_s model(input logic [7:0] r);
      jlp_note_s n;
      n.rd = r;
      n.cfg = {m[0][7], 6'h01 + m[0][4:0], 9'h001 + m[1], 6'h01 + m[2][4:0], 9'h001 + m[3],
         m[5][7:5] == 3'h1, 6'h01 + m[6][4:0], m[7][7], m[8], m[10]};
      n.chk = {{1'b0, m[9]} != 9'h001 + m[1], m[4][7:6] != 2'h0, m[4][4:0] != 5'h0F,
         m[5][4:0] != 5'h0F, m[6][7:5] != 3'h1, m[7][4:0] != 5'h00, m[5][7:5] > 3'h1,
         m[3] == 8'h00 && m[0][4:0] == 5'h01 && m[2][4:0] != 5'h1F};
      return n;
   endfunction

   // One access: note the expectation, run the frame, then signal the watcher.
   task automatic acc(input logic rd, input logic [14:0] a, input logic [7:0] wd);
      int j;
      j = -1;
      for (int i = 0; i < 11; i++)
         if (jlp_pkg::REG_ADDR[i] == a)
            j = i;
      if (!rd && j >= 0)
         m[j] = wd;
      notes.push_back(model((rd && j >= 0) ? m[j] : 8'h00));
      i_jlp_spi_host.xfer(rd, a, wd, rdat);
      -> done_ev;
   endtask

   // Watcher takes the oldest note whenever an access completes.
   always @(done_ev)
   begin
      cur = notes.pop_front();
      `CHK("read data", cur.rd, rdat)
      // The decode is split in two at bit 24: descramble enable with the lane, octet, frame and converter counts, then the remaining fields.
      `CHK("link cfg counts", cur.cfg[54:24], link_cfg_out[54:24])
      `CHK("link cfg modes", cur.cfg[23:0], link_cfg_out[23:0])
      `CHK("cfg flags", cur.chk, cfg_check_out)
   end

   // Verdict and end of run.
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog, well beyond the roughly 30600 cycles that the sequence takes.
   initial
   begin
      #600000;
      errors++;
      end_sim();
   end

   // Reset, reset values, the three modes, an illegal K, an unmapped place, random traffic.
   initial
   begin
      m = jlp_pkg::REG_RESET;
      repeat (6) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      repeat (4) @(posedge ref_clk_in);
      for (int i = 0; i < 11; i++)
         acc(1'b1, jlp_pkg::REG_ADDR[i], 8'h00);
      for (int md = 0; md < 3; md++)
         for (int i = 0; i < 22; i++)
            acc(i >= 11, jlp_pkg::REG_ADDR[i % 11], MODES[md][i % 11]);
      acc(1'b0, jlp_pkg::ADDR_FRAMES_PER_MULTIFRAME_CFG, 8'h0F);
      acc(1'b0, 15'h0460, 8'hA5);
      acc(1'b1, 15'h0460, 8'h00);
      repeat (20)
      begin
         k = {$random(seed)} % 11;
         d = 8'($random(seed));
         if (k == 1)
            d[7] = 1'b0;
         acc(1'b0, jlp_pkg::REG_ADDR[k], d);
         acc(1'b1, jlp_pkg::REG_ADDR[k], 8'h00);
      end
      // Let the watcher take the last note before the run is closed.
      @(posedge ref_clk_in);
      end_sim();
   end
endmodule

// >>> sim/jlp_spi_host.sv
// Serial host model that runs one register access per call of xfer.
// Assumes mode 0 timing with sclk at one tenth of ref_clk_in.
`timescale 1ns/10ps
module jlp_spi_host
(
   // Clock.
   input  wire logic ref_clk_in,
   // Serial pins.
   output logic      sclk_out,
   output logic      csb_n_out,
   output logic      sdi_out,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in
);
   // Idle pins, sclk stands low between frames.
   initial
   begin
      sclk_out = 1'b0;
      csb_n_out = 1'b1;
      sdi_out = 1'b0;
   end

   // One frame: instruction then one byte; a read bit seen without enable becomes unknown.
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [23:0] sh;
      sh = {rd, a, d};
      q = 8'h00;
      @(posedge ref_clk_in) #1 csb_n_out = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sdi_out = sh[i];
         repeat (5) @(posedge ref_clk_in);
         #1 sclk_out = 1'b1;
         if (rd && i < 8)
            q = {q[6:0], sdo_oe_in === 1'b1 ? sdo_in : 1'bx};
         repeat (5) @(posedge ref_clk_in);
         #1 sclk_out = 1'b0;
      end
      repeat (8) @(posedge ref_clk_in);
      #1 csb_n_out = 1'b1;
      sdi_out = ~sdi_out; // Released line shows the inverse of its last value.
      repeat (6) @(posedge ref_clk_in);
      #1;
   endtask
endmodule
